// file: hdl/card_mode_decode.sv
// Card access mode decoder from address bits 23 to 21
`timescale 1ns/1ns
`include "ebi_mux_consts.svh"
module card_mode_decode
  import ebi_mux_pkg::*;
(
  input wire logic [2:0] mode_bits,
  output card_mode_t mode
);
  always_comb begin // see RULE18
    case (mode_bits)
      3'h0: mode = MODE_ATTR;
      3'h2: mode = MODE_COMMON;
      3'h4: mode = MODE_IO;
      3'h6: mode = MODE_IDE;
      3'h7: mode = MODE_ALT_IDE;
      default: mode = MODE_NONE;
    endcase
  end
endmodule : card_mode_decode

// file: hdl/ebi_card_nand_pin_mux.sv
// Card and flash pin multiplexer of the external bus interface
//
// Behaviour
// RULE1 - Card assign bits turn chip select 4/5 pins into card selects 0/1.
// RULE2 - A pin given to the card serves no other memory device.
// RULE3 - Card accesses put card strobes and direction on shared strobe and A25 pins.
// RULE4 - Card select 0 follows the chip select 4 waveform exactly.
// RULE5 - Card read-not-write stays stable for the whole transfer.
// RULE6 - Flash logic serves the chip select 3 region when assigned.
// RULE7 - With chip select 3 active, read/write strobes drive flash enables.
// RULE8 - Flash enables drop as soon as address leaves chip select 3 region.
// RULE9 - A21 is flash address latch, A22 command latch enable.
// RULE10 - Software tells flash words apart by offset in the region.
// RULE11 - Flash chip enable and ready/busy live on general-purpose pins.
// RULE12 - Chip select 0 resets to byte select, 16 bits, slow clock.
// RULE13 - A23 picks card I/O or memory, A22 gives register select.
// RULE14 - A21 picks alternate or primary IDE registers.
// RULE15 - A 32-bit bus needs software width and pin setup.
// RULE16 - Card reset, interrupt and detect use general-purpose pins.
// RULE17 - I/O and IDE use I/O strobes; memory uses enable strobes; IDE holds OE low.
// RULE18 - Card mode decoded from A23..A21: 000,010,100,110,111.
// RULE19 - Assign bits are static; selection follows the active chip select.
`timescale 1ns/1ns
`include "ebi_mux_consts.svh"
module ebi_card_nand_pin_mux
  import ebi_mux_pkg::*;
#(
  parameter int ADDR_WIDTH = `ADDR_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic card_slot0_assign,
  input wire logic card_slot1_assign,
  input wire logic nand_region_assign,
  input wire logic [31:0] xfer_addr,
  input wire logic xfer_write,
  input wire logic [ADDR_WIDTH-1:0] smc_addr,
  input wire logic chip_select_0_in_n,
  input wire logic chip_select_3_in_n,
  input wire logic chip_select_4_in_n,
  input wire logic chip_select_5_in_n,
  input wire logic read_strobe_in_n,
  input wire logic write_enable_in_n,
  input wire logic write_strobe1_in_n,
  input wire logic write_strobe3_in_n,
  output logic chip_select_0_n,
  output logic chip_select_3_n,
  output logic chip_select_4_n,
  output logic chip_select_5_n,
  output logic read_strobe_n,
  output logic write_enable_n,
  output logic write_strobe1_n,
  output logic write_strobe3_n,
  output logic [ADDR_WIDTH-1:0] addr_out,
  output logic flash_output_enable,
  output logic flash_write_enable,
  output logic flash_addr_latch,
  output logic flash_cmd_latch,
  output logic cs0_byte_select,
  output logic [1:0] cs0_data_width,
  output logic cs0_rw_by_cs,
  output logic cs0_slow_clock
);
  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  card_mode_t mode;
  logic card_cs4;
  logic card_cs5;
  logic card_acc;
  logic nand_hit;
  logic io_strobes;
  logic oe_low;
  logic nxt_rnw;
  logic rnw_ff;
  logic card_acc_ff;

  card_mode_decode u_mode (
    .mode_bits(smc_addr[`ADDR_MODE_HI:`ADDR_MODE_LO]),
    .mode(mode)
  );

  assign card_cs4 = card_slot0_assign & ~chip_select_4_in_n; // see RULE19
  assign card_cs5 = card_slot1_assign & ~chip_select_5_in_n; // see RULE19
  assign card_acc = card_cs4 | card_cs5;
  assign nand_hit = nand_region_assign & (xfer_addr >= `NAND_REGION_BASE)
                    & (xfer_addr <= `NAND_REGION_LAST); // see RULE6
  assign io_strobes = (mode == MODE_IO) | (mode == MODE_IDE) | (mode == MODE_ALT_IDE); // see RULE13
  assign oe_low = (mode == MODE_IDE) | (mode == MODE_ALT_IDE); // see RULE14

  // Direction taken in the first card cycle, then held to the end
  assign nxt_rnw = (card_acc && card_acc_ff) ? rnw_ff : ~xfer_write; // see RULE5

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rnw_ff <= 1'h1;
    end else if (clk_en) begin
      rnw_ff <= nxt_rnw;
    end
  end

  // Card access seen in the previous cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      card_acc_ff <= 1'h0;
    end else if (clk_en) begin
      card_acc_ff <= card_acc; // see RULE5
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chip_select_0_n <= 1'h1;
      chip_select_3_n <= 1'h1;
      chip_select_4_n <= 1'h1;
      chip_select_5_n <= 1'h1;
      read_strobe_n <= 1'h1;
      write_enable_n <= 1'h1;
      write_strobe1_n <= 1'h1;
      write_strobe3_n <= 1'h1;
      addr_out <= '0;
      flash_output_enable <= 1'h1;
      flash_write_enable <= 1'h1;
      flash_addr_latch <= 1'h0;
      flash_cmd_latch <= 1'h0;
    end else if (clk_en) begin
      chip_select_0_n <= chip_select_0_in_n;
      chip_select_3_n <= chip_select_3_in_n;
      // Same waveform either way, pin meaning set by assign bit
      chip_select_4_n <= chip_select_4_in_n; // see RULE1, RULE4
      chip_select_5_n <= chip_select_5_in_n; // see RULE1
      addr_out <= smc_addr;
      if (card_acc) begin // see RULE3
        addr_out[`ADDR_RNW_PIN] <= nxt_rnw; // see RULE5
        if (io_strobes) begin // see RULE17
          read_strobe_n <= ~oe_low;
          write_enable_n <= 1'h1;
          write_strobe1_n <= read_strobe_in_n;
          write_strobe3_n <= write_enable_in_n;
        end else begin
          read_strobe_n <= read_strobe_in_n;
          write_enable_n <= write_enable_in_n;
          write_strobe1_n <= 1'h1;
          write_strobe3_n <= 1'h1;
        end
      end else begin
        read_strobe_n <= read_strobe_in_n;
        write_enable_n <= write_enable_in_n;
        write_strobe1_n <= write_strobe1_in_n;
        write_strobe3_n <= write_strobe3_in_n;
      end
      if (nand_hit && !chip_select_3_in_n) begin // see RULE7
        flash_output_enable <= read_strobe_in_n;
        flash_write_enable <= write_enable_in_n;
      end else begin // see RULE8
        flash_output_enable <= 1'h1;
        flash_write_enable <= 1'h1;
      end
      flash_addr_latch <= nand_hit & smc_addr[`ADDR_ALE]; // see RULE9
      flash_cmd_latch <= nand_hit & smc_addr[`ADDR_CLE]; // see RULE9
    end
  end

  // ----------------------------------------------------------------
  // Chip select 0 boot defaults
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin // see RULE12
      cs0_byte_select <= `CS0_RST_BYTE_SELECT;
      cs0_data_width <= `CS0_RST_DBW;
      cs0_rw_by_cs <= `CS0_RST_RW_BY_CS;
      cs0_slow_clock <= `CS0_RST_SLOW_CLK;
    end
  end
endmodule : ebi_card_nand_pin_mux

// file: hdl/ebi_mux_consts.svh
// Constants for the card and flash pin multiplexer
`ifndef EBI_MUX_CONSTS_SVH
`define EBI_MUX_CONSTS_SVH
`define ADDR_W 26
`define ADDR_MODE_HI 23
`define ADDR_MODE_LO 21
`define ADDR_ALE 21
`define ADDR_CLE 22
`define ADDR_REG 22
`define ADDR_RNW_PIN 25
`define NAND_REGION_BASE 32'h40000000
`define NAND_REGION_LAST 32'h4fffffff
`define CS0_RST_BYTE_SELECT 1'h1
`define CS0_RST_DBW 2'h1
`define CS0_RST_RW_BY_CS 1'h1
`define CS0_RST_SLOW_CLK 1'h1
`endif

// file: hdl/ebi_mux_pkg.sv
// Types for the card and flash pin multiplexer
package ebi_mux_pkg;
  typedef enum logic [2:0] {
    MODE_ATTR,
    MODE_COMMON,
    MODE_IO,
    MODE_IDE,
    MODE_ALT_IDE,
    MODE_NONE
  } card_mode_t;
  typedef enum logic [1:0] {
    DBW_8,
    DBW_16,
    DBW_32
  } data_width_t;
endpackage : ebi_mux_pkg

// file: verification/flash_model.sv
// Far-side flash model counting command strobes
`timescale 1ns/1ns
module flash_model (
  input wire logic clk_sys,
  input wire logic flash_write_enable,
  input wire logic flash_cmd_latch,
  output logic [7:0] cmd_count
);
  initial cmd_count = 8'h0;
  always @(posedge clk_sys) begin
    if (!flash_write_enable && flash_cmd_latch) cmd_count <= cmd_count + 8'h1;
  end
endmodule : flash_model

// file: verification/pin_mux_checker.sv
// Checker for the card and flash pin multiplexer
`timescale 1ns/1ns
module pin_mux_checker #(parameter int ADDR_WIDTH = 26) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic card_slot0_assign,
  input wire logic nand_region_assign,
  input wire logic chip_select_3_in_n,
  input wire logic chip_select_4_in_n,
  input wire logic read_strobe_in_n,
  input wire logic chip_select_4_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe1_n,
  input wire logic flash_output_enable,
  input wire logic flash_write_enable,
  input wire logic [31:0] xfer_addr,
  input wire logic [ADDR_WIDTH-1:0] smc_addr,
  input wire logic [ADDR_WIDTH-1:0] addr_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire c0 = clk_en && card_slot0_assign && !chip_select_4_in_n;
  wire hit = clk_en && nand_region_assign && !chip_select_3_in_n && xfer_addr[31:28] == 4'h4;
  a_cs4_copy: assert property (clk_en |=> chip_select_4_n == $past(chip_select_4_in_n))
    else $error("card select mismatch");
  a_io_read: assert property (c0 && smc_addr[23:21] == 3'h4 |=>
    write_strobe1_n == $past(read_strobe_in_n) && read_strobe_n) else $error("io read wrong");
  a_mem_read: assert property (c0 && smc_addr[23:21] == 3'h2 |=>
    read_strobe_n == $past(read_strobe_in_n) && write_strobe1_n) else $error("mem read wrong");
  a_ide_oe: assert property (c0 && smc_addr[23:22] == 2'h3 |=> !read_strobe_n)
    else $error("ide oe not low");
  a_rnw_held: assert property (c0 ##1 c0 |=> $stable(addr_out[ADDR_WIDTH-1]))
    else $error("direction moved");
  a_flash_off: assert property (clk_en && xfer_addr[31:28] != 4'h4 |=>
    flash_output_enable && flash_write_enable) else $error("flash strobe outside region");
  a_flash_idle: assert property (clk_en && chip_select_3_in_n |=> flash_output_enable)
    else $error("flash oe without select");
  a_flash_oe: assert property (hit |=> flash_output_enable == $past(read_strobe_in_n))
    else $error("flash oe not routed");
  a_frozen_hold: assert property (!clk_en |=> $stable(chip_select_4_n))
    else $error("select moved while frozen");
endmodule : pin_mux_checker
bind ebi_card_nand_pin_mux pin_mux_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk_i (.*);

// file: verification/testbench.sv
// Testbench for the card and flash pin multiplexer
`timescale 1ns/1ns
module testbench;
  logic clk_sys = 1'h0, nrst, clk_en, card_slot0_assign, card_slot1_assign, nand_region_assign;
  logic xfer_write, chip_select_0_in_n, chip_select_3_in_n, chip_select_4_in_n, chip_select_5_in_n;
  logic read_strobe_in_n, write_enable_in_n, write_strobe1_in_n, write_strobe3_in_n, dir, pcd;
  logic chip_select_0_n, chip_select_3_n, chip_select_4_n, chip_select_5_n, read_strobe_n;
  logic write_enable_n, write_strobe1_n, write_strobe3_n, flash_output_enable, flash_write_enable;
  logic flash_addr_latch, flash_cmd_latch, cs0_byte_select, cs0_rw_by_cs, cs0_slow_clock;
  logic [1:0] cs0_data_width;
  logic [31:0] xfer_addr;
  logic [25:0] smc_addr, addr_out;
  logic [7:0] cmd_count;
  logic [2:0] md [5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
  int errors = 0, check_count = 0;
  ebi_card_nand_pin_mux uut (.*);
  flash_model far (.*);
  always #2 clk_sys = ~clk_sys;
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task acc(input logic [3:0] c, input logic [31:0] xa, input logic [25:0] sa,
           input logic [3:0] st, input logic w);
    logic cd, h, e25;
    logic [3:0] es;
    {chip_select_0_in_n, chip_select_3_in_n, chip_select_4_in_n, chip_select_5_in_n} = c;
    {read_strobe_in_n, write_enable_in_n, write_strobe1_in_n, write_strobe3_in_n} = st;
    {xfer_addr, smc_addr, xfer_write} = {xa, sa, w};
    cd = (card_slot0_assign && !c[1]) || (card_slot1_assign && !c[0]);
    h = nand_region_assign && !c[2] && xa[31:28] == 4'h4;
    es = !cd ? st : (sa[23] && sa[23:21] != 3'h5) ? {~sa[22], 1'h1, st[3:2]} : {st[3:2], 2'h3};
    if (!(cd && pcd)) dir = ~w;
    e25 = cd ? dir : sa[25];
    pcd = cd;
    @(negedge clk_sys);
    chk({chip_select_0_n, chip_select_3_n, chip_select_4_n, chip_select_5_n, read_strobe_n,
      write_enable_n, write_strobe1_n, write_strobe3_n}, {c, es});
    chk(addr_out, {e25, sa[24:0]});
    chk({flash_output_enable, flash_write_enable, flash_addr_latch, flash_cmd_latch},
      {h ? st[3:2] : 2'h3, h & sa[21], h & sa[22]});
  endtask : acc
  task finish_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    {nrst, clk_en, card_slot0_assign, card_slot1_assign, nand_region_assign, dir} = 6'h10;
    pcd = 1'h0;
    acc(4'hf, 32'h0, 26'h0, 4'hf, 1'h0);
    repeat (11) @(negedge clk_sys);
    nrst = 1'h1;
    chk({cs0_byte_select, cs0_data_width, cs0_rw_by_cs, cs0_slow_clock}, 32'h17);
    acc(4'h7, 32'h10000000, 26'h2abcdef, 4'h5, 1'h0);
    acc(4'hd, 32'h50000000, 26'h3e00001, 4'ha, 1'h1);
    $display("plain test done");
    {card_slot0_assign, card_slot1_assign} = 2'h3;
    for (int i = 0; i < 10; i++) begin
      acc(4'hf, 32'h0, 26'h0, 4'hf, i[0]);
      for (int k = 0; k < 2; k++) begin
        acc(i < 5 ? 4'hd : 4'he, 32'h50000000, {i[0], 1'h0, md[i % 5], 21'h155},
          i[0] ? 4'hb : 4'h7, i[0] ^ k[0]);
      end
    end
    $display("card test done");
    nand_region_assign = 1'h1;
    acc(4'hb, 32'h40000000, 26'h400000, 4'hb, 1'h1);
    acc(4'hb, 32'h4fffffff, 26'h200000, 4'h7, 1'h0);
    acc(4'hb, 32'h50000000, 26'h600000, 4'h3, 1'h1);
    acc(4'hf, 32'h40000000, 26'h0, 4'h3, 1'h0);
    chk(cmd_count, 32'h1);
    $display("flash test done");
    clk_en = 1'h0;
    {chip_select_0_in_n, chip_select_3_in_n, chip_select_4_in_n, chip_select_5_in_n} = 4'h0;
    read_strobe_in_n = 1'h1;
    @(negedge clk_sys);
    chk({chip_select_0_n, chip_select_3_n, chip_select_4_n, chip_select_5_n, read_strobe_n},
      32'h1e);
    clk_en = 1'h1;
    $display("hold test done");
    finish_test;
  end
endmodule : testbench
